// ---- src/link_map_pkg.sv ----
package link_map_pkg;
   localparam int WORD_W      = 16;
   localparam int BITS_W      = 32;
   localparam int NUM_WORDS   = 4;
   localparam int NUM_FUNCS   = 17;
   localparam int STATION_W   = 7;
   localparam int BIT_IDX_W   = 12;
   localparam int WORD_IDX_W  = 10;
   // Input function positions in the command bit vector
   localparam int CB_SERVO_ENABLE   = 0;
   localparam int CB_FORWARD_START  = 1;
   localparam int CB_REVERSE_START  = 2;
   localparam int CB_PROXIMITY_DOG  = 3;
   localparam int CB_FWD_STROKE_END = 4;
   localparam int CB_REV_STROKE_END = 5;
   localparam int CB_AUTO_MANUAL    = 6;
   localparam int CB_PAUSE_RESTART  = 7;
   localparam int CB_MONITOR_REQ    = 8;
   localparam int CB_INSTR_REQ      = 9;
   localparam int CB_POINT_LSB      = 10;
   localparam int CB_CLEAR_REQ      = 15;
   localparam int CB_FAULT_RESET    = 26;
   // Function slot of fault reset in the selection vector
   localparam int FN_FAULT_RESET    = 16;
   // Command bits that carry a function; all others ignored
   localparam logic [31:0] CMD_USED_MASK = 32'h0400_FFFF;
   // Factory source: 1 = connector; dog, forward and reverse stroke end
   localparam logic [16:0] SRC_SEL_DEFAULT = 17'h0_0038;
   // Status positions
   localparam int SB_READY       = 0;
   localparam int SB_IN_POSITION = 1;
   localparam int SB_ROUGH_MATCH = 2;
   localparam int SB_HOME_DONE   = 3;
   localparam int SB_TORQUE_LIM  = 4;
   localparam int SB_BRAKE_ILK   = 6;
   localparam int SB_PAUSED      = 7;
   localparam int SB_MONITORING  = 8;
   localparam int SB_INSTR_DONE  = 9;
   localparam int SB_WARNING     = 10;
   localparam int SB_BATT_WARN   = 11;
   localparam int SB_MOVE_DONE   = 12;
   localparam int SB_DYN_BRAKE   = 13;
   localparam int SB_POS_RANGE   = 14;
   localparam int SB_ALARM       = 26;
   localparam int SB_LINK_READY  = 27;
   // Word slots
   localparam int W_MON1   = 0;
   localparam int W_MON2   = 1;
   localparam int W_INSTR  = 2;
   localparam int W_DATA   = 3;
   // Points per station and words per station
   localparam int BITS_PER_STATION  = 32;
   localparam int WORDS_PER_STATION = 4;
endpackage

// ---- src/input_select_cell.sv ----
`timescale 1ns/1ps
module input_select_cell (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic link_bit,
   input  wire logic conn_bit,
   input  wire logic use_conn,
   output logic      func_q
);
   logic func_d;

   always_comb begin
      func_d = use_conn ? conn_bit : link_bit;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         func_q <= 1'b0;
      end else begin
         func_q <= func_d;
      end
   end
endmodule // input_select_cell

// ---- src/servo_link_io_map_one_station.sv ----
`timescale 1ns/1ps
module servo_link_io_map_one_station (
   input  wire logic        clk,
   input  wire logic        rst,
   // Station number switch, held stable while running
   input  wire logic [6:0]  station_number,
   // Link refresh: command side from the master
   input  wire logic        link_refresh,
   input  wire logic [31:0] cmd_bits,
   input  wire logic [15:0] cmd_word0,
   input  wire logic [15:0] cmd_word1,
   input  wire logic [15:0] cmd_word2,
   input  wire logic [15:0] cmd_word3,
   // Input source selection
   input  wire logic        src_sel_load,
   input  wire logic [16:0] src_sel_value,
   // External connector inputs, one per input function
   input  wire logic [16:0] conn_inputs,
   // Drive state feeding the status bits
   input  wire logic        ready,
   input  wire logic        in_position,
   input  wire logic        rough_match,
   input  wire logic        home_return_done,
   input  wire logic        torque_limiting,
   input  wire logic        brake_interlock,
   input  wire logic        paused_flag,
   input  wire logic        monitoring_active,
   input  wire logic        instruction_complete,
   input  wire logic        warning_flag,
   input  wire logic        battery_warning,
   input  wire logic        movement_complete,
   input  wire logic        dynamic_brake_interlock,
   input  wire logic        position_range_output,
   input  wire logic        alarm_indication,
   input  wire logic        link_station_ready,
   // Drive values feeding the response words
   input  wire logic [15:0] monitor_one_data,
   input  wire logic [15:0] monitor_two_data,
   input  wire logic [15:0] response_code_data,
   input  wire logic [15:0] read_data,
   // Link side answers
   output logic [31:0]      status_bits_q,
   output logic [15:0]      monitor_one_value_q,
   output logic [15:0]      monitor_two_value_q,
   output logic [15:0]      response_code_word_q,
   output logic [15:0]      read_data_word_q,
   // Command words handed to the drive
   output logic [15:0]      monitor_one_select_q,
   output logic [15:0]      monitor_two_select_q,
   output logic [15:0]      instruction_word_q,
   output logic [15:0]      write_data_word_q,
   // Effective input functions
   output logic [16:0]      func_q,
   output logic [16:0]      src_sel_q,
   // Connector outputs mirroring status
   output logic             conn_ready_q,
   output logic             conn_home_done_q,
   output logic             conn_alarm_q,
   // Base device indices
   output logic [11:0]      base_bit_index_q,
   output logic [9:0]       base_word_index_q
);
   logic [31:0] cmd_bits_q;
   logic [31:0] cmd_bits_d;
   logic [15:0] mon1_sel_d;
   logic [15:0] mon2_sel_d;
   logic [15:0] instr_d;
   logic [15:0] wdata_d;
   logic [16:0] src_sel_d;
   logic [16:0] link_funcs;
   logic [31:0] status_d;
   logic [6:0]  station_q;
   logic [6:0]  station_d;
   logic        station_valid_q;
   logic [11:0] base_bit_d;
   logic [9:0]  base_word_d;
   logic [6:0]  station_off;

   // Command latch: taken whole on each refresh so a half update never leaks
   always_comb begin
      cmd_bits_d = cmd_bits_q;
      mon1_sel_d = monitor_one_select_q;
      mon2_sel_d = monitor_two_select_q;
      instr_d    = instruction_word_q;
      wdata_d    = write_data_word_q;
      if (link_refresh) begin
         cmd_bits_d = cmd_bits & link_map_pkg::CMD_USED_MASK;
         mon1_sel_d = cmd_word0;
         mon2_sel_d = cmd_word1;
         instr_d    = cmd_word2;
         wdata_d    = cmd_word3;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_bits_q           <= 32'h0000_0000;
         monitor_one_select_q <= 16'h0000;
         monitor_two_select_q <= 16'h0000;
         instruction_word_q   <= 16'h0000;
         write_data_word_q    <= 16'h0000;
      end else begin
         cmd_bits_q           <= cmd_bits_d;
         monitor_one_select_q <= mon1_sel_d;
         monitor_two_select_q <= mon2_sel_d;
         instruction_word_q   <= instr_d;
         write_data_word_q    <= wdata_d;
      end
   end

   // Source selection
   always_comb begin
      src_sel_d = src_sel_q;
      if (src_sel_load) begin
         src_sel_d = src_sel_value;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         src_sel_q <= link_map_pkg::SRC_SEL_DEFAULT;
      end else begin
         src_sel_q <= src_sel_d;
      end
   end

   // Command bits 0..15 map straight onto slots 0..15, fault reset (bit 26) onto slot 16
   always_comb begin
      link_funcs = {cmd_bits_q[link_map_pkg::CB_FAULT_RESET],
                    cmd_bits_q[15:0]};
   end

   genvar gi;
   generate
      for (gi = 0; gi < link_map_pkg::NUM_FUNCS; gi++) begin : g_sel
         input_select_cell u_cell (
            .clk      (clk),
            .rst      (rst),
            .link_bit (link_funcs[gi]),
            .conn_bit (conn_inputs[gi]),
            .use_conn (src_sel_q[gi]),
            .func_q   (func_q[gi])
         );
      end
   endgenerate

   // Status assembly; reserved positions stay zero
   always_comb begin
      status_d = 32'h0000_0000;
      status_d[link_map_pkg::SB_READY]       = ready;
      status_d[link_map_pkg::SB_IN_POSITION] = in_position;
      status_d[link_map_pkg::SB_ROUGH_MATCH] = rough_match;
      status_d[link_map_pkg::SB_HOME_DONE]   = home_return_done;
      status_d[link_map_pkg::SB_TORQUE_LIM]  = torque_limiting;
      status_d[link_map_pkg::SB_BRAKE_ILK]   = brake_interlock;
      status_d[link_map_pkg::SB_PAUSED]      = paused_flag;
      status_d[link_map_pkg::SB_MONITORING]  = monitoring_active;
      status_d[link_map_pkg::SB_INSTR_DONE]  = instruction_complete;
      status_d[link_map_pkg::SB_WARNING]     = warning_flag;
      status_d[link_map_pkg::SB_BATT_WARN]   = battery_warning;
      status_d[link_map_pkg::SB_MOVE_DONE]   = movement_complete;
      status_d[link_map_pkg::SB_DYN_BRAKE]   = dynamic_brake_interlock;
      status_d[link_map_pkg::SB_POS_RANGE]   = position_range_output;
      status_d[link_map_pkg::SB_ALARM]       = alarm_indication;
      status_d[link_map_pkg::SB_LINK_READY]  = link_station_ready;
   end

   // Link and connector copies share one register stage so they never skew
   always_ff @(posedge clk) begin
      if (rst) begin
         status_bits_q        <= 32'h0000_0000;
         conn_ready_q         <= 1'b0;
         conn_home_done_q     <= 1'b0;
         conn_alarm_q         <= 1'b0;
         monitor_one_value_q  <= 16'h0000;
         monitor_two_value_q  <= 16'h0000;
         response_code_word_q <= 16'h0000;
         read_data_word_q     <= 16'h0000;
      end else begin
         status_bits_q        <= status_d;
         conn_ready_q         <= status_d[link_map_pkg::SB_READY];
         conn_home_done_q     <= status_d[link_map_pkg::SB_HOME_DONE];
         conn_alarm_q         <= status_d[link_map_pkg::SB_ALARM];
         monitor_one_value_q  <= monitor_one_data;
         monitor_two_value_q  <= monitor_two_data;
         response_code_word_q <= response_code_data;
         read_data_word_q     <= read_data;
      end
   end

   // Station number caught once after reset; switch changes need a reset
   always_comb begin
      station_d = station_valid_q ? station_q : station_number;
      station_off = (station_q == 7'h00) ? 7'h00 : station_q - 7'h01;
      base_bit_d  = 12'(station_off)
                    * 12'(link_map_pkg::BITS_PER_STATION);
      base_word_d = 10'(station_off)
                    * 10'(link_map_pkg::WORDS_PER_STATION);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         station_q         <= 7'h00;
         station_valid_q   <= 1'b0;
         base_bit_index_q  <= 12'h000;
         base_word_index_q <= 10'h000;
      end else begin
         station_q         <= station_d;
         station_valid_q   <= 1'b1;
         base_bit_index_q  <= base_bit_d;
         base_word_index_q <= base_word_d;
      end
   end
endmodule // servo_link_io_map_one_station

// ---- tb/link_master_model.sv ----
`timescale 1ns/1ps
module link_master_model (
   input  wire logic   clk,
   output logic        link_refresh,
   output logic [31:0] cmd_bits,
   output logic [15:0] cmd_word0,
   output logic [15:0] cmd_word1,
   output logic [15:0] cmd_word2,
   output logic [15:0] cmd_word3
);
   initial begin
      link_refresh = 1'b0;
      cmd_bits = 32'h0;
      {cmd_word0, cmd_word1, cmd_word2, cmd_word3} = 64'h0;
   end
   // Payload is inverted after the refresh so stale data cannot pass
   task automatic send(input logic [31:0] b, input logic [63:0] w);
      @(posedge clk);
      #1;
      link_refresh = 1'b1;
      cmd_bits = b;
      {cmd_word0, cmd_word1, cmd_word2, cmd_word3} = w;
      @(posedge clk);
      #1;
      link_refresh = 1'b0;
      cmd_bits = ~b;
      {cmd_word0, cmd_word1, cmd_word2, cmd_word3} = ~w;
   endtask
endmodule // link_master_model

// ---- tb/servo_link_io_map_one_station_chk.sv ----
`timescale 1ns/1ps
module servo_link_io_map_one_station_chk (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        link_refresh,
   input wire logic [31:0] cmd_bits,
   input wire logic [15:0] cmd_word2,
   input wire logic        src_sel_load,
   input wire logic [16:0] src_sel_value,
   input wire logic        ready,
   input wire logic        alarm_indication,
   input wire logic        link_station_ready,
   input wire logic [15:0] response_code_data,
   input wire logic [31:0] status_bits_q,
   input wire logic [15:0] response_code_word_q,
   input wire logic [15:0] instruction_word_q,
   input wire logic [16:0] func_q,
   input wire logic [16:0] src_sel_q,
   input wire logic        conn_ready_q,
   input wire logic        conn_alarm_q,
   input wire logic [11:0] base_bit_index_q,
   input wire logic [9:0]  base_word_index_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_ready_mirror: assert property (p_ready_mirror) else $error("ready");
   property p_ready_mirror;
      !$past(rst) |-> status_bits_q[0] == $past(ready)
         && conn_ready_q == $past(ready);
   endproperty
   a_alarm_mirror: assert property (p_alarm_mirror)
      else $error("alarm");
   property p_alarm_mirror;
      !$past(rst) |-> conn_alarm_q == $past(alarm_indication) && status_bits_q
         [27:26] == {$past(link_station_ready), $past(alarm_indication)};
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("rsvd");
   property p_reserved_zero;
      (status_bits_q & 32'hF3FF_8020) == 32'h0;
   endproperty
   a_resp_word: assert property (p_resp_word) else $error("resp");
   property p_resp_word;
      !$past(rst) |-> response_code_word_q == $past(response_code_data);
   endproperty
   a_instr_take: assert property (p_instr_take) else $error("take");
   property p_instr_take;
      link_refresh |=> instruction_word_q == $past(cmd_word2);
   endproperty
   a_instr_hold: assert property (p_instr_hold) else $error("hold");
   property p_instr_hold;
      !link_refresh |=> $stable(instruction_word_q);
   endproperty
   a_src_default: assert property (p_src_default) else $error("dflt");
   property p_src_default;
      $past(rst) |-> src_sel_q == 17'h0_0038;
   endproperty
   a_src_load: assert property (p_src_load) else $error("load");
   property p_src_load;
      src_sel_load |=> src_sel_q == $past(src_sel_value);
   endproperty
   a_fault_link: assert property (p_fault_link) else $error("fault");
   property p_fault_link;
      link_refresh && !src_sel_q[16] && !src_sel_load
         |-> ##2 func_q[16] == $past(cmd_bits[26], 2);
   endproperty
   a_base_ratio: assert property (p_base_ratio) else $error("base");
   property p_base_ratio;
      base_bit_index_q == {base_word_index_q[8:0], 3'h0};
   endproperty
endmodule // servo_link_io_map_one_station_chk
bind servo_link_io_map_one_station servo_link_io_map_one_station_chk i_chk (
   .clk, .rst, .link_refresh, .cmd_bits, .cmd_word2, .src_sel_load,
   .src_sel_value, .ready, .alarm_indication, .link_station_ready,
   .response_code_data, .status_bits_q, .response_code_word_q,
   .instruction_word_q, .func_q, .src_sel_q, .conn_ready_q, .conn_alarm_q,
   .base_bit_index_q, .base_word_index_q);

// ---- tb/servo_link_io_map_one_station_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module servo_link_io_map_one_station_tb;
   logic        clk, rst, src_sel_load, link_refresh;
   logic        conn_ready_q, conn_home_done_q, conn_alarm_q;
   logic [6:0]  station_number;
   logic [31:0] cmd_bits, status_bits_q;
   logic [15:0] cmd_word0, cmd_word1, cmd_word2, cmd_word3, st;
   logic [16:0] src_sel_value, conn_inputs, func_q, src_sel_q;
   logic [63:0] dw, rw, sw;
   logic [11:0] base_bit_index_q;
   logic [9:0]  base_word_index_q;
   int          error_cnt = 0;
   int          checks = 0;
   link_master_model i_link_master_model (.clk(clk),
      .link_refresh(link_refresh), .cmd_bits(cmd_bits), .cmd_word0(cmd_word0),
      .cmd_word1(cmd_word1), .cmd_word2(cmd_word2), .cmd_word3(cmd_word3));
   servo_link_io_map_one_station i_servo_link_io_map_one_station (
      .clk(clk), .rst(rst), .station_number(station_number),
      .link_refresh(link_refresh), .cmd_bits(cmd_bits), .cmd_word0(cmd_word0),
      .cmd_word1(cmd_word1), .cmd_word2(cmd_word2), .cmd_word3(cmd_word3),
      .src_sel_load(src_sel_load), .src_sel_value(src_sel_value),
      .conn_inputs(conn_inputs), .ready(st[0]), .in_position(st[1]),
      .rough_match(st[2]), .home_return_done(st[3]), .torque_limiting(st[4]),
      .brake_interlock(st[5]), .paused_flag(st[6]),
      .monitoring_active(st[7]), .instruction_complete(st[8]),
      .warning_flag(st[9]), .battery_warning(st[10]),
      .movement_complete(st[11]), .dynamic_brake_interlock(st[12]),
      .position_range_output(st[13]), .alarm_indication(st[14]),
      .link_station_ready(st[15]), .monitor_one_data(dw[63:48]),
      .monitor_two_data(dw[47:32]), .response_code_data(dw[31:16]),
      .read_data(dw[15:0]), .status_bits_q(status_bits_q),
      .monitor_one_value_q(rw[63:48]), .monitor_two_value_q(rw[47:32]),
      .response_code_word_q(rw[31:16]), .read_data_word_q(rw[15:0]),
      .monitor_one_select_q(sw[63:48]), .monitor_two_select_q(sw[47:32]),
      .instruction_word_q(sw[31:16]), .write_data_word_q(sw[15:0]),
      .func_q(func_q), .src_sel_q(src_sel_q), .conn_ready_q(conn_ready_q),
      .conn_home_done_q(conn_home_done_q), .conn_alarm_q(conn_alarm_q),
      .base_bit_index_q(base_bit_index_q),
      .base_word_index_q(base_word_index_q));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic load_sel(input logic [16:0] v);
      src_sel_load = 1'b1;
      src_sel_value = v;
      tick(1);
      src_sel_load = 1'b0;
   endtask
   task automatic test_reset;
      tick(3);
      `CHK("src_sel", 17'h0_0038, src_sel_q)
      `CHK("base_bit", 12'h080, base_bit_index_q)
      `CHK("base_word", 10'h010, base_word_index_q)
      $display("reset test done");
   endtask
   task automatic test_status;
      int pos [16] = '{0, 1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 12, 13, 14, 26, 27};
      for (int i = 0; i < 16; i++) begin
         st = 16'h1 << i;
         tick(2);
         `CHK("status", 32'h1 << pos[i], status_bits_q)
         `CHK("conn", {i == 14, i == 3, i == 0},
            {conn_alarm_q, conn_home_done_q, conn_ready_q})
      end
      st = 16'h0;
      $display("status test done");
   endtask
   task automatic test_words;
      dw = 64'h1234_5678_9ABC_DEF0;
      tick(2);
      `CHK("resp", 64'h1234_5678_9ABC_DEF0, rw)
      i_link_master_model.send(32'h0, 64'hA5A5_5A5A_0F0F_F0F0);
      `CHK("select", 64'hA5A5_5A5A_0F0F_F0F0, sw)
      // Bus now shows the inverse with no refresh: words must not move
      tick(2);
      `CHK("select_hold", 64'hA5A5_5A5A_0F0F_F0F0, sw)
      $display("word test done");
   endtask
   task automatic test_link_cmd;
      // Connector held high: link selection must hide it
      load_sel(17'h0);
      conn_inputs = 17'h1_FFFF;
      i_link_master_model.send(32'hFFFF_FFFF, 64'h0);
      tick(1);
      `CHK("func_all", 17'h1_FFFF, func_q)
      i_link_master_model.send(32'h0400_0000, 64'h0);
      tick(1);
      `CHK("func_reset", 17'h1_0000, func_q)
      i_link_master_model.send(32'hFBFF_0000, 64'h0);
      tick(1);
      `CHK("func_rsvd", 17'h0, func_q)
      $display("link command test done");
   endtask
   task automatic test_conn;
      load_sel(17'h0_0038);
      conn_inputs = 17'h0;
      i_link_master_model.send(32'h0000_FFFF, 64'h0);
      tick(1);
      `CHK("func_dflt", 17'h0_FFC7, func_q)
      conn_inputs = 17'h0_0028;
      tick(3);
      `CHK("func_conn", 17'h0_FFEF, func_q)
      $display("connector test done");
   endtask
   task automatic reset_to(input logic [6:0] s);
      station_number = s;
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      tick(3);
   endtask
   task automatic test_station;
      // Switch moved while running must not shift the map before a reset
      load_sel(17'h1_FFFF);
      conn_inputs = 17'h1_FFFF;
      station_number = 7'h40;
      tick(3);
      `CHK("base_hold", 12'h080, base_bit_index_q)
      reset_to(7'h40);
      `CHK("base_bit64", 12'h7E0, base_bit_index_q)
      `CHK("base_word64", 10'h0FC, base_word_index_q)
      `CHK("src_rst", 17'h0_0038, src_sel_q)
      `CHK("func_rst", 17'h0_0038, func_q)
      `CHK("sel_rst", 64'h0, sw)
      reset_to(7'h01);
      `CHK("base_bit1", 12'h000, base_bit_index_q)
      `CHK("base_word1", 10'h000, base_word_index_q)
      $display("station test done");
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      station_number = 7'h05;
      src_sel_load = 1'b0;
      src_sel_value = 17'h0;
      conn_inputs = 17'h0;
      st = 16'h0;
      dw = 64'h0;
      tick(4);
      rst = 1'b0;
      test_reset;
      test_status;
      test_words;
      test_link_cmd;
      test_conn;
      test_station;
      complete_run;
   end
endmodule // servo_link_io_map_one_station_tb
